// ### verilog/sensor_host_defs.svh
// register map, field positions and timing constants of the sensor host controller
`ifndef SENSOR_HOST_DEFS_SVH
`define SENSOR_HOST_DEFS_SVH
`define REG_CMD 8'h00
`define REG_STATUS 8'h04
`define REG_RXDATA 8'h08
`define REG_MOT_HI 8'h0c
`define REG_MOT_LO 8'h10
`define CMD_OP_LSB 0
`define CMD_ADDR_LSB 8
`define CMD_DATA_LSB 16
`define STAT_BUSY_BIT 0
`define STAT_BURST_BIT 1
`define STAT_FWCNT_LSB 16
`define DEV_FW_ENABLE_ADDR 7'h14
`define DEV_FW_LOAD_ADDR 7'h60
`define FW_IMAGE_BYTES 11'h7c2
`define MOTION_BYTES 3'h7
`define CLK_PERIOD_NS 10
`define T_SCLK_HALF_NS 80
`define T_ADDR_DLY_NS 50000
`define T_MOT_DLY_NS 75000
`define T_LOAD_NS 10000
`define T_BEXIT_NS 500
`define T_TXN_NS 50000
`define T_RESET_NS 10000
`define T_RESYNC_NS 1000000
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### verilog/sensor_host_pkg.sv
// types of the sensor host controller
package sensor_host_pkg;
  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_WRITE = 3'h1, OP_MOTION = 3'h2, OP_FW_BYTE = 3'h3,
    OP_PIX_BYTE = 3'h4, OP_END = 3'h5, OP_HWRST = 3'h6, OP_RESYNC = 3'h7
  } op_e;
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_SHIFT, ST_GAP, ST_EXIT, ST_RSTP} state_e;
  typedef struct packed {
    state_e st;
    op_e op;
    logic [23:0] tmr;
    logic [2:0] bit_i;
    logic [2:0] byte_i;
    logic [2:0] nbytes;
    logic [7:0] sh;
    logic [7:0] rx;
    logic [7:0] wdata;
    logic [55:0] motion;
    logic [10:0] fw_cnt;
    logic addr_ph;
    logic half;
    logic burst_on;
    logic miso_a;
    logic miso_b;
    logic sclk;
    logic mosi;
    logic cs_n;
    logic rst;
    logic awready;
    logic wready;
    logic bvalid;
    logic arready;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [7:0] awaddr;
    logic [3:0] wst;
    logic [31:0] wd;
    logic [31:0] rdata;
  } ctl_s;
endpackage

// ### verilog/sensor_host.sv
// host controller driving the optical sensor serial port, commanded over axi4-lite
//
// Summary of operation
// - after motion address, wait delay, then clock all bytes without gaps.
// - end motion burst by holding chip select high; nothing else runs meanwhile.
// - firmware start: reset pulse, enable writes to 0x14, then burst to 0x60; the first OP_FW_BYTE sends the 0x60 burst address, then its data byte.
// - firmware bytes follow at normal clock rate with load interval between them.
// - end download with chip select high for burst exit time.
// - pixel burst: one normal read, then further bytes each at least load interval.
// - raising chip select aborts a pixel burst at any time.
// - chip select high for 1 ms resynchronises the serial port.
// - chip select rising mid-transfer aborts; normal delays still precede next transfer.
// - host pulses the reset pin after every power-up; this controller pulses it only on an OP_HWRST command.
// - address byte: seven address bits, msb one for write, zero for read.
`timescale 1ns/1ps
`include "sensor_host_defs.svh"
module sensor_host
  import sensor_host_pkg::*;
#(
  parameter int unsigned HALF_CYC = `CYC_UP(`T_SCLK_HALF_NS),
  parameter int unsigned ADDR_DLY_CYC = `CYC_UP(`T_ADDR_DLY_NS),
  parameter int unsigned MOT_DLY_CYC = `CYC_UP(`T_MOT_DLY_NS),
  parameter int unsigned LOAD_CYC = `CYC_UP(`T_LOAD_NS),
  parameter int unsigned BEXIT_CYC = `CYC_UP(`T_BEXIT_NS),
  parameter int unsigned TXN_CYC = `CYC_UP(`T_TXN_NS),
  parameter int unsigned RESET_CYC = `CYC_UP(`T_RESET_NS),
  parameter int unsigned RESYNC_CYC = `CYC_UP(`T_RESYNC_NS)
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [7:0] axi_awaddr_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  output logic [1:0] axi_bresp_out,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  input wire logic [7:0] axi_araddr_in,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  output logic sclk_out,
  output logic mosi_out,
  input wire logic miso_in,
  output logic chip_select_n_out,
  output logic sensor_reset_out
);
  if (HALF_CYC < 4 || RESET_CYC < 4 || ADDR_DLY_CYC < 1 || MOT_DLY_CYC < 1 || LOAD_CYC < 1 ||
      BEXIT_CYC < 1 || TXN_CYC < 1 || RESYNC_CYC < 1 || RESYNC_CYC >= 2**24 ||
      TXN_CYC >= 2**24 || ADDR_DLY_CYC >= 2**24 || MOT_DLY_CYC >= 2**24) begin : g_bad_param
    $error("sensor_host: timing parameter out of range");
  end

  localparam logic [23:0] T_HALF = 24'(HALF_CYC - 1);
  localparam logic [23:0] T_ADDR = 24'(ADDR_DLY_CYC - 1);
  localparam logic [23:0] T_MOT = 24'(MOT_DLY_CYC - 1);
  localparam logic [23:0] T_LOAD = 24'(LOAD_CYC - 1);
  localparam logic [23:0] T_BEXIT = 24'(BEXIT_CYC - 1);
  localparam logic [23:0] T_TXN = 24'(TXN_CYC - 1);
  localparam logic [23:0] T_RESET = 24'(RESET_CYC - 1);
  localparam logic [23:0] T_RESYNC = 24'(RESYNC_CYC - 1);
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ctl_s q;
  ctl_s next_q;

  function automatic logic op_legal(input op_e op, input ctl_s s);
    unique case (op)
      OP_FW_BYTE: op_legal = s.fw_cnt < `FW_IMAGE_BYTES && (!s.burst_on || s.op == OP_FW_BYTE);
      OP_PIX_BYTE: op_legal = !s.burst_on || s.op == OP_PIX_BYTE;
      OP_END, OP_HWRST, OP_RESYNC: op_legal = 1'b1;
      default: op_legal = !s.burst_on;
    endcase
  endfunction

  function automatic logic [32:0] rd_word(input logic [7:0] a, input ctl_s s);
    logic [31:0] st;
    st = '0;
    st[`STAT_BUSY_BIT] = s.st != ST_IDLE;
    st[`STAT_BURST_BIT] = s.burst_on;
    st[`STAT_FWCNT_LSB +: 11] = s.fw_cnt;
    unique case (a)
      `REG_STATUS: rd_word = {1'b1, st};
      `REG_RXDATA: rd_word = {1'b1, 24'h0, s.rx};
      `REG_MOT_HI: rd_word = {1'b1, s.motion[55:24]};
      `REG_MOT_LO: rd_word = {1'b1, 8'h0, s.motion[23:0]};
      default: rd_word = 33'h0;
    endcase
  endfunction

  always_comb begin
    logic [7:0] sh_new;
    logic go;
    logic setup;
    logic [32:0] rw;
    op_e cop;
    sh_new = {q.sh[6:0], q.miso_b};
    go = 1'b0;
    setup = 1'b0;
    rw = rd_word(axi_araddr_in, q);
    cop = op_e'(q.wd[`CMD_OP_LSB +: 3]);
    next_q = q;
    next_q.miso_a = miso_in;
    next_q.miso_b = q.miso_a;
    unique case (q.st)
      ST_IDLE: begin
      end
      ST_SETUP: begin
        if (q.tmr == 24'h0) begin
          go = 1'b1;
        end else begin
          next_q.tmr = q.tmr - 24'h1;
        end
      end
      ST_SHIFT: begin
        if (q.tmr != 24'h0) begin
          next_q.tmr = q.tmr - 24'h1;
        end else if (!q.half) begin
          next_q.sclk = 1'b1;
          next_q.half = 1'b1;
          next_q.tmr = T_HALF;
        end else begin
          // miso is taken at the end of the high phase, the device holds it until the next fall
          next_q.sh = sh_new;
          next_q.bit_i = q.bit_i + 3'h1;
          if (q.bit_i != 3'h7) begin
            next_q.sclk = 1'b0;
            next_q.mosi = q.sh[6];
            next_q.half = 1'b0;
            next_q.tmr = T_HALF;
          end else if (q.addr_ph) begin
            next_q.addr_ph = 1'b0;
            if (q.op == OP_WRITE || q.op == OP_FW_BYTE) begin
              next_q.sh = q.wdata;
              go = 1'b1;
            end else begin
              next_q.sh = 8'h0;
              next_q.st = ST_GAP;
              next_q.tmr = (q.op == OP_MOTION) ? T_MOT : T_ADDR;
            end
          end else begin
            next_q.rx = sh_new;
            if (q.op == OP_MOTION) begin
              next_q.motion = {q.motion[47:0], sh_new};
            end
            next_q.byte_i = q.byte_i + 3'h1;
            if (q.byte_i + 3'h1 < q.nbytes) begin
              next_q.sh = 8'h0;
              go = 1'b1;
            end else if (q.op == OP_FW_BYTE || q.op == OP_PIX_BYTE) begin
              next_q.st = ST_GAP;
              next_q.tmr = T_LOAD;
            end else begin
              next_q.cs_n = 1'b1;
              next_q.st = ST_EXIT;
              next_q.tmr = (q.op == OP_MOTION) ? T_BEXIT : T_TXN;
            end
          end
        end
      end
      ST_GAP: begin
        if (q.tmr != 24'h0) begin
          next_q.tmr = q.tmr - 24'h1;
        end else if (q.byte_i < q.nbytes) begin
          go = 1'b1;
        end else begin
          next_q.st = ST_IDLE;
        end
      end
      ST_EXIT: begin
        if (q.tmr == 24'h0) begin
          next_q.st = ST_IDLE;
        end else begin
          next_q.tmr = q.tmr - 24'h1;
        end
      end
      ST_RSTP: begin
        if (q.tmr == 24'h0) begin
          next_q.rst = 1'b0;
          next_q.st = ST_EXIT;
          next_q.tmr = T_TXN;
        end else begin
          next_q.tmr = q.tmr - 24'h1;
        end
      end
    endcase
    // write channel: address and data in either order, response after both
    if (axi_awvalid_in && q.awready) begin
      next_q.awready = 1'b0;
      next_q.awaddr = axi_awaddr_in;
    end
    if (axi_wvalid_in && q.wready) begin
      next_q.wready = 1'b0;
      next_q.wd = axi_wdata_in;
      next_q.wst = axi_wstrb_in;
    end
    if (q.bvalid && axi_bready_in) begin
      next_q.bvalid = 1'b0;
      next_q.awready = 1'b1;
      next_q.wready = 1'b1;
    end
    if (!q.awready && !q.wready && !q.bvalid) begin
      next_q.bvalid = 1'b1;
      next_q.bresp = RESP_SLVERR;
      if (q.awaddr == `REG_CMD && q.wst == 4'hf && q.st == ST_IDLE && op_legal(cop, q)) begin
        next_q.bresp = RESP_OK;
        next_q.op = cop;
        next_q.wdata = q.wd[`CMD_DATA_LSB +: 8];
        next_q.byte_i = 3'h0;
        next_q.nbytes = 3'h1;
        next_q.addr_ph = 1'b1;
        next_q.sh = {cop == OP_WRITE, q.wd[`CMD_ADDR_LSB +: 7]};
        setup = 1'b1;
        unique case (cop)
          OP_MOTION: next_q.nbytes = `MOTION_BYTES;
          OP_FW_BYTE: begin
            next_q.fw_cnt = q.fw_cnt + 11'h1;
            next_q.burst_on = 1'b1;
            if (q.burst_on) begin
              next_q.addr_ph = 1'b0;
              next_q.sh = q.wd[`CMD_DATA_LSB +: 8];
              setup = 1'b0;
              go = 1'b1;
            end else begin
              next_q.sh = {1'b1, `DEV_FW_LOAD_ADDR};
            end
          end
          OP_PIX_BYTE: begin
            next_q.burst_on = 1'b1;
            if (q.burst_on) begin
              next_q.addr_ph = 1'b0;
              next_q.sh = 8'h0;
              setup = 1'b0;
              go = 1'b1;
            end
          end
          OP_END, OP_RESYNC: begin
            setup = 1'b0;
            next_q.cs_n = 1'b1;
            next_q.burst_on = 1'b0;
            next_q.st = ST_EXIT;
            next_q.tmr = (cop == OP_END) ? T_BEXIT : T_RESYNC;
          end
          OP_HWRST: begin
            setup = 1'b0;
            next_q.rst = 1'b1;
            next_q.cs_n = 1'b1;
            next_q.burst_on = 1'b0;
            next_q.fw_cnt = 11'h0;
            next_q.st = ST_RSTP;
            next_q.tmr = T_RESET;
          end
          default: begin
          end
        endcase
      end
    end
    if (setup) begin
      next_q.st = ST_SETUP;
      next_q.cs_n = 1'b0;
      next_q.tmr = T_HALF;
    end
    if (go) begin
      next_q.st = ST_SHIFT;
      next_q.sclk = 1'b0;
      next_q.mosi = next_q.sh[7];
      next_q.half = 1'b0;
      next_q.bit_i = 3'h0;
      next_q.tmr = T_HALF;
    end
    // read channel
    if (q.rvalid && axi_rready_in) begin
      next_q.rvalid = 1'b0;
      next_q.arready = 1'b1;
    end
    if (axi_arvalid_in && q.arready) begin
      next_q.arready = 1'b0;
      next_q.rvalid = 1'b1;
      next_q.rdata = rw[31:0];
      next_q.rresp = rw[32] ? RESP_OK : RESP_SLVERR;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '0;
      q.sclk <= 1'b1;
      q.cs_n <= 1'b1;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign axi_awready_out = q.awready;
  assign axi_wready_out = q.wready;
  assign axi_bvalid_out = q.bvalid;
  assign axi_bresp_out = q.bresp;
  assign axi_arready_out = q.arready;
  assign axi_rvalid_out = q.rvalid;
  assign axi_rdata_out = q.rdata;
  assign axi_rresp_out = q.rresp;
  assign sclk_out = q.sclk;
  assign mosi_out = q.mosi;
  assign chip_select_n_out = q.cs_n;
  assign sensor_reset_out = q.rst;

  // cycles that chip select has been high, saturating
  logic [23:0] cs_hi_cnt;
  localparam int MIN_GAP = (BEXIT_CYC < TXN_CYC) ? BEXIT_CYC : TXN_CYC;
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cs_hi_cnt <= '1;
    end else if (!q.cs_n) begin
      cs_hi_cnt <= 24'h0;
    end else if (cs_hi_cnt != '1) begin
      cs_hi_cnt <= cs_hi_cnt + 24'h1;
    end
  end

  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  property p_cs_gap;
    $fell(q.cs_n) |-> cs_hi_cnt >= 24'(MIN_GAP);
  endproperty
  a_cs_gap: assert property (p_cs_gap) else $error("chip select high too short");
  property p_exit_cs;
    q.st == ST_EXIT |-> q.cs_n && !q.burst_on && q.sclk;
  endproperty
  a_exit_cs: assert property (p_exit_cs) else $error("exit with chip select low");
  property p_dir_bit;
    q.st == ST_SHIFT && q.addr_ph && q.bit_i == 3'h0 && !q.sclk |->
      q.mosi == (q.op == OP_WRITE || q.op == OP_FW_BYTE);
  endproperty
  a_dir_bit: assert property (p_dir_bit) else $error("wrong direction bit");
  property p_mosi_edge;
    $changed(q.mosi) |-> !q.sclk && !q.cs_n;
  endproperty
  a_mosi_edge: assert property (p_mosi_edge) else $error("mosi moved outside low sclk");
  property p_rst_pulse;
    $rose(q.rst) |-> q.rst [*4] ##1 q.cs_n;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too short");
  property p_fw_cap;
    q.fw_cnt <= `FW_IMAGE_BYTES;
  endproperty
  a_fw_cap: assert property (p_fw_cap) else $error("firmware bytes beyond image");
  property p_motion_b2b;
    q.st == ST_SHIFT && q.op == OP_MOTION && !q.addr_ph && q.bit_i == 3'h7 && q.half &&
      q.tmr == 24'h0 && q.byte_i < 3'h6 |=> q.st == ST_SHIFT && !q.sclk;
  endproperty
  a_motion_b2b: assert property (p_motion_b2b) else $error("gap inside motion burst");
  property p_bhold;
    q.bvalid && !axi_bready_in |=> q.bvalid && $stable(q.bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    q.rvalid && !axi_rready_in |=> q.rvalid && $stable(q.rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  c_motion: cover property (q.op == OP_MOTION && $rose(q.cs_n));
  c_fw_burst: cover property (q.op == OP_FW_BYTE && q.burst_on && q.st == ST_SHIFT && !q.addr_ph);
  c_resync: cover property (q.op == OP_RESYNC && q.st == ST_EXIT);
endmodule

// ### sim/sensor_model.sv
// behavioural optical sensor serial port answering the host controller
`timescale 1ns/1ps
module sensor_model #(
  parameter logic [6:0] MOT_A = 7'h50,
  parameter logic [6:0] PIX_A = 7'h64,
  parameter logic [6:0] CAP_A = 7'h12,
  parameter logic [6:0] CFG_A = 7'h0f
) (
  input wire logic sclk_in,
  input wire logic mosi_in,
  input wire logic chip_select_n_in,
  input wire logic reset_in,
  output logic miso_out
);
  logic [7:0] sh, ob, cfg, fw_en, fw_last;
  logic [6:0] addr;
  logic wr, captured;
  logic reset_seen = 1'b0;
  int bits, nbyte, fw_cnt;

  function automatic logic [7:0] rd_byte(input logic [6:0] a, input int i);
    if (a == MOT_A) return (i < 7) ? 8'(8'ha1 + i) : 8'h00;
    if (a == PIX_A) return (captured && i < 1536) ? {1'b1, (i == 0 || i == 900), 6'(i % 64)} : 8'h00;
    if (a == CFG_A) return cfg;
    return 8'h00;
  endfunction

  // no power-up reset: state stays unknown until the reset pin is pulsed
  always @(posedge sclk_in or posedge chip_select_n_in or posedge reset_in) begin
    if (reset_in) begin
      captured = 1'b0;
      fw_cnt = 0;
      fw_en = 8'h00;
      cfg = 8'h00;
      reset_seen = 1'b1;
    end else if (chip_select_n_in) begin
      bits = 0;
      nbyte = 0;
    end else begin
      sh = {sh[6:0], mosi_in};
      bits = bits + 1;
      if (bits == 8) begin
        bits = 0;
        if (nbyte == 0) begin
          addr = sh[6:0];
          wr = sh[7];
          ob = rd_byte(sh[6:0], 0);
        end else if (!wr) begin
          ob = rd_byte(addr, nbyte);
        end else if (addr == 7'h60) begin
          if (fw_en == 8'h18 && fw_cnt < 1986) begin
            fw_cnt = fw_cnt + 1;
            fw_last = sh;
          end
        end else if (nbyte == 1) begin
          if (addr == CFG_A) cfg = sh;
          if (addr == 7'h14) fw_en = sh;
          if (addr == CAP_A) begin
            captured = 1'b1;
            fw_cnt = 0;
            fw_en = 8'h00;
          end
        end
        nbyte = nbyte + 1;
      end
    end
  end

  // released line shows the inverse of its last level
  always @(negedge sclk_in or posedge chip_select_n_in) begin
    if (chip_select_n_in) miso_out = ~miso_out;
    else miso_out = ob[7 - bits];
  end
endmodule

// ### sim/tb.sv
// testbench of the sensor host controller against the sensor model
`timescale 1ns/1ps
module tb
  import sensor_host_pkg::*;
;
  localparam logic [6:0] MOT_A = 7'h50;
  localparam logic [6:0] PIX_A = 7'h64;
  localparam logic [6:0] CAP_A = 7'h12;
  localparam logic [6:0] CFG_A = 7'h0f;
  localparam logic [6:0] FREE_A = 7'h33;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, sclk, mosi, miso, cs_n, srst;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  int num_errors = 0;
  int samples_checked = 0;

  // motion delay, burst exit and reset pulse keep their defaults so the block runs as built
  sensor_host #(.HALF_CYC(4), .ADDR_DLY_CYC(20), .LOAD_CYC(10), .TXN_CYC(20),
    .RESYNC_CYC(50)) sensor_host_inst (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .axi_awvalid_in(awvalid), .axi_awready_out(awready), .axi_awaddr_in(awaddr),
    .axi_wvalid_in(wvalid), .axi_wready_out(wready), .axi_wdata_in(wdata), .axi_wstrb_in(wstrb),
    .axi_bvalid_out(bvalid), .axi_bready_in(bready), .axi_bresp_out(bresp),
    .axi_arvalid_in(arvalid), .axi_arready_out(arready), .axi_araddr_in(araddr),
    .axi_rvalid_out(rvalid), .axi_rready_in(rready), .axi_rdata_out(rdata), .axi_rresp_out(rresp),
    .sclk_out(sclk), .mosi_out(mosi), .miso_in(miso), .chip_select_n_out(cs_n), .sensor_reset_out(srst));

  sensor_model #(.MOT_A(MOT_A), .PIX_A(PIX_A), .CAP_A(CAP_A), .CFG_A(CFG_A)) sensor_model_inst (
    .sclk_in(sclk), .mosi_in(mosi), .chip_select_n_in(cs_n), .reset_in(srst), .miso_out(miso));

  initial begin
    forever #5 clock_in = ~clock_in;
  end

  task finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #1500000;
    num_errors++;
    finish_test();
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task axw(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] resp);
    @(posedge clock_in);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    wstrb <= s;
    bready <= 1'b1;
    forever begin
      @(posedge clock_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask

  task axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clock_in);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    forever begin
      @(posedge clock_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  function automatic logic [31:0] cw(input op_e op, input logic [6:0] a, input logic [7:0] v);
    return {8'h00, v, 1'b0, a, 5'h00, op};
  endfunction

  function automatic logic [7:0] pix(input int i);
    return {1'b1, (i == 0 || i == 900), 6'(i % 64)};
  endfunction

  // issue a command and wait until the controller is idle again
  task cmd(input op_e op, input logic [6:0] a, input logic [7:0] v);
    logic [1:0] rr;
    logic [31:0] st;
    axw(8'h00, cw(op, a, v), 4'hf, rr);
    st = 32'h1;
    while (st[0] !== 1'b0) axr(8'h04, st, rr);
  endtask

  task rx(input logic [31:0] exp);
    axr(8'h08, d, r);
    check(d & 32'hff, exp);
  endtask

  initial begin
    repeat (5) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    @(posedge clock_in);
    check(32'({sclk, cs_n, srst}), 32'h6);
    axr(8'h04, d, r);
    check(d, 32'h0);
    axr(8'h1c, d, r);
    check(d, 32'h0);
    check(32'(r), 32'h2);
    $display("test reset done");
    cmd(OP_HWRST, 7'h00, 8'h00);
    check(32'(sensor_model_inst.reset_seen), 32'h1);
    cmd(OP_WRITE, CFG_A, 8'h5a);
    cmd(OP_READ, CFG_A, 8'h00);
    rx(32'h5a);
    cmd(OP_WRITE, FREE_A, 8'h77);
    cmd(OP_READ, FREE_A, 8'h00);
    rx(32'h0);
    axw(8'h00, cw(OP_WRITE, CFG_A, 8'h11), 4'h3, r);
    check(32'(r), 32'h2);
    axw(8'h20, 32'h0, 4'hf, r);
    check(32'(r), 32'h2);
    $display("test registers done");
    cmd(OP_MOTION, MOT_A, 8'h00);
    axr(8'h0c, d, r);
    check(d, 32'ha1a2a3a4);
    axr(8'h10, d, r);
    check(d & 32'hffffff, 32'ha5a6a7);
    $display("test motion done");
    cmd(OP_WRITE, 7'h14, 8'h1d);
    cmd(OP_WRITE, 7'h14, 8'h18);
    for (int i = 0; i < 3; i++) cmd(OP_FW_BYTE, 7'h00, 8'(8'hc0 + i));
    axr(8'h04, d, r);
    check(d, 32'h00030002);
    axw(8'h00, cw(OP_READ, CFG_A, 8'h00), 4'hf, r);
    check(32'(r), 32'h2);
    cmd(OP_END, 7'h00, 8'h00);
    check(32'(sensor_model_inst.fw_cnt), 32'h3);
    check(32'(sensor_model_inst.fw_last), 32'hc2);
    axr(8'h04, d, r);
    check(d & 32'h3, 32'h0);
    $display("test firmware done");
    cmd(OP_PIX_BYTE, PIX_A, 8'h00);
    rx(32'h0);
    cmd(OP_END, 7'h00, 8'h00);
    cmd(OP_WRITE, CAP_A, 8'h00);
    check(32'(sensor_model_inst.fw_cnt), 32'h0);
    for (int i = 0; i < 902; i++) begin
      cmd(OP_PIX_BYTE, PIX_A, 8'h00);
      rx(32'(pix(i)));
    end
    cmd(OP_END, 7'h00, 8'h00);
    check(32'(sensor_model_inst.nbyte), 32'h0);
    $display("test pixel done");
    cmd(OP_RESYNC, 7'h00, 8'h00);
    cmd(OP_READ, CFG_A, 8'h00);
    rx(32'h5a);
    $display("test resync done");
    finish_test();
  end
endmodule
